//--- verilog/i2ccs_defines.svh
`ifndef I2CCS_DEFINES_SVH
`define I2CCS_DEFINES_SVH

// register byte addresses
`define I2CCS_BUS_CONTROL_ADDR 8'h00
`define I2CCS_BUS_STATUS_ADDR  8'h04
`define I2CCS_TX_DATA_ADDR     8'h08
`define I2CCS_RX_DATA_ADDR     8'h0c

// bus_control field positions
`define I2CCS_PE_BIT   0
`define I2CCS_ROLE_LO  1
`define I2CCS_ROLE_HI  2
`define I2CCS_SPEED_LO 4
`define I2CCS_SPEED_HI 5
`define I2CCS_GCH_BIT  6
`define I2CCS_TXF_BIT  7
`define I2CCS_RXF_BIT  8
`define I2CCS_DTX_BIT  9
`define I2CCS_DRX_BIT  10
`define I2CCS_FLT_LO   13
`define I2CCS_FLT_HI   14
`define I2CCS_FS_BIT   15
`define I2CCS_CTRL_MASK  32'h0000e7f7
`define I2CCS_CTRL_RESET 32'h00000000

// bus responses
`define I2CCS_RESP_OKAY   2'b00
`define I2CCS_RESP_SLVERR 2'b10

// timing
`define I2CCS_CLK_NS       100
`define I2CCS_HALF_STD_NS  5000
`define I2CCS_HALF_FAST_NS 1250
`define I2CCS_HALF_STD_CYC \
  ((`I2CCS_HALF_STD_NS + `I2CCS_CLK_NS - 1) / `I2CCS_CLK_NS)
`define I2CCS_HALF_FAST_CYC \
  ((`I2CCS_HALF_FAST_NS + `I2CCS_CLK_NS - 1) / `I2CCS_CLK_NS)
`define I2CCS_FLUSH_CYC    3
`define I2CCS_OWN_ADDR     7'h55
`define I2CCS_FIFO_DEPTH   4

`endif

//--- verilog/i2ccs_pkg.sv
`default_nettype none
package i2ccs_pkg;
  // serial engine states
  typedef enum logic [3:0] {
    I2CCS_S_IDLE = 4'b0001,
    I2CCS_S_ADDR = 4'b0010,
    I2CCS_S_RX   = 4'b0100,
    I2CCS_S_TX   = 4'b1000
  } i2ccs_state_t;
  // forced stop sequencer
  typedef enum logic [2:0] {
    I2CCS_F_IDLE = 3'b001,
    I2CCS_F_LOW  = 3'b010,
    I2CCS_F_REL  = 3'b100
  } i2ccs_fstop_t;
  typedef logic [1:0] i2ccs_flt_t;
endpackage
`default_nettype wire

//--- verilog/i2ccs_top.sv
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`include "i2ccs_defines.svh"
`default_nettype none

// small synchronous FIFO, count based
module i2ccs_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         clr,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;
  assign in_ready  = (cnt_reg != (AW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rp_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end
  // pointers and count
  always_ff @(posedge sys_clk) begin
    if (rst || clr) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wp_reg <= wp_reg + AW'(1);
      if (pop) rp_reg <= rp_reg + AW'(1);
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // i2ccs_fifo

// line synchroniser plus spike filter
module i2ccs_glitch (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                pin,
  input  wire i2ccs_pkg::i2ccs_flt_t sel,
  output logic                     level
);
  import i2ccs_pkg::*;
  logic       s1_reg;
  logic       s2_reg;
  logic [2:0] cnt_reg;
  logic [2:0] need;
  // 01/10/11 reject 1/2/4 wide spikes
  always_comb begin
    unique case (sel)
      2'b00: need = 3'h0;
      2'b01: need = 3'h1;
      2'b10: need = 3'h2;
      2'b11: need = 3'h4;
    endcase
  end
  // two flops before any logic sees the pin
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
    end
  end
  // accept a new level only once it outlasts the spike width
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level   <= 1'b1;
      cnt_reg <= 3'h0;
    end else if (s2_reg == level) begin
      cnt_reg <= 3'h0;
    end else if (cnt_reg >= need) begin
      level   <= s2_reg;
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end
endmodule // i2ccs_glitch

module i2ccs_top (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             dma_tx_req,
  input  wire logic        dma_tx_eot,
  output logic             dma_rx_req,
  input  wire logic        dma_rx_eot
);
  import i2ccs_pkg::*;

  logic [31:0]  ctrl_reg;
  i2ccs_state_t state_reg;
  i2ccs_fstop_t fs_reg;
  logic [3:0]   bit_reg;
  logic [7:0]   shift_reg;
  logic [7:0]   code_reg;
  logic         gc_reg;
  logic         pend_reg;
  logic [1:0]   txf_cnt_reg;
  logic [1:0]   rxf_cnt_reg;
  logic [5:0]   fs_cnt_reg;
  logic         scl_f, sda_f, scl_d_reg, sda_d_reg;
  logic         scl_rise, scl_fall, start_c, stop_c;
  logic         wr_go, rd_go, wr_ok;
  logic [31:0]  wmask, set_ones, hw_clr;
  logic         tx_in_ready, tx_out_valid, tx_pop;
  logic [7:0]   tx_out_data;
  logic         rx_in_ready, rx_out_valid, rx_push, rx_pop;
  logic [7:0]   rx_out_data;
  logic         pe, txf, rxf, match, direct_gc;
  logic [5:0]   half_cyc;

  assign pe  = ctrl_reg[`I2CCS_PE_BIT];
  assign txf = ctrl_reg[`I2CCS_TXF_BIT];
  assign rxf = ctrl_reg[`I2CCS_RXF_BIT];
  // stop setup time follows the selected bus speed
  assign half_cyc = ctrl_reg[`I2CCS_SPEED_LO] ?
                    6'(`I2CCS_HALF_FAST_CYC) : 6'(`I2CCS_HALF_STD_CYC);

  // filtered lines and bus conditions
  i2ccs_glitch u_scl (.sys_clk(sys_clk), .rst(rst), .pin(scl_in),
    .sel(ctrl_reg[`I2CCS_FLT_HI:`I2CCS_FLT_LO]), .level(scl_f));
  i2ccs_glitch u_sda (.sys_clk(sys_clk), .rst(rst), .pin(sda_in),
    .sel(ctrl_reg[`I2CCS_FLT_HI:`I2CCS_FLT_LO]), .level(sda_f));
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
    end
  end
  assign scl_rise = scl_f & ~scl_d_reg;
  assign scl_fall = ~scl_f & scl_d_reg;
  assign start_c  = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
  assign stop_c   = scl_f & scl_d_reg & ~sda_d_reg & sda_f;

  // address match; a master-only role is never addressed
  assign match = pe && (ctrl_reg[`I2CCS_ROLE_HI:`I2CCS_ROLE_LO] != 2'b01)
    && ((shift_reg[7:1] == `I2CCS_OWN_ADDR) || (shift_reg == 8'h00));
  // direct mode consumes software general calls, never hardware ones
  assign direct_gc = gc_reg && ctrl_reg[`I2CCS_GCH_BIT]
                     && !shift_reg[0];

  // fifos: receive back-pressure stretches the clock line
  i2ccs_fifo #(.W(8), .D(`I2CCS_FIFO_DEPTH)) u_txq (
    .sys_clk(sys_clk), .rst(rst), .clr(txf || !pe),
    .in_valid(wr_go && s_axi_awaddr == `I2CCS_TX_DATA_ADDR
              && s_axi_wstrb[0]),
    .in_ready(tx_in_ready), .in_data(s_axi_wdata[7:0]),
    .out_valid(tx_out_valid), .out_ready(tx_pop),
    .out_data(tx_out_data));
  i2ccs_fifo #(.W(8), .D(`I2CCS_FIFO_DEPTH)) u_rxq (
    .sys_clk(sys_clk), .rst(rst), .clr(rxf || !pe),
    .in_valid(rx_push), .in_ready(rx_in_ready), .in_data(shift_reg),
    .out_valid(rx_out_valid), .out_ready(rx_pop),
    .out_data(rx_out_data));
  assign rx_push = pend_reg && pe;
  assign tx_pop  = (state_reg == I2CCS_S_TX) && scl_fall
                   && bit_reg == 4'h9 && tx_out_valid;
  assign rx_pop  = rd_go && s_axi_araddr == `I2CCS_RX_DATA_ADDR;

  // serial engine; either flush or disable returns it to idle
  always_ff @(posedge sys_clk) begin
    if (rst || !pe || txf || rxf || stop_c) begin
      state_reg <= I2CCS_S_IDLE;
      bit_reg   <= 4'h0;
      gc_reg    <= 1'b0;
      pend_reg  <= 1'b0;
    end else if (start_c) begin
      state_reg <= I2CCS_S_ADDR;
      bit_reg   <= 4'h0;
      pend_reg  <= 1'b0;
    end else if (pend_reg) begin
      if (rx_in_ready) pend_reg <= 1'b0;
    end else if (scl_rise) begin
      if (bit_reg < 4'h8 && state_reg != I2CCS_S_TX) begin
        shift_reg <= {shift_reg[6:0], sda_f};
      end
      if (bit_reg == 4'h8 && state_reg == I2CCS_S_TX && sda_f) begin
        state_reg <= I2CCS_S_IDLE; // master nack ends the read
      end
      bit_reg <= bit_reg + 4'h1;
    end else if (scl_fall && bit_reg == 4'h8) begin
      unique case (state_reg)
        I2CCS_S_ADDR: begin
          if (!match) begin
            state_reg <= I2CCS_S_IDLE;
          end else if (shift_reg[0] && shift_reg[7:1] != 7'h00) begin
            state_reg <= I2CCS_S_TX;
          end else begin
            state_reg <= I2CCS_S_RX;
            gc_reg    <= (shift_reg == 8'h00);
          end
        end
        I2CCS_S_RX: begin
          if (!direct_gc) pend_reg <= 1'b1;
          gc_reg <= 1'b0;
        end
        default: ;
      endcase
    end else if (scl_fall && bit_reg == 4'h9) begin
      bit_reg <= 4'h0;
      if (state_reg == I2CCS_S_TX) begin
        shift_reg <= tx_out_valid ? tx_out_data : 8'hff;
      end
    end else if (scl_fall && state_reg == I2CCS_S_TX) begin
      shift_reg <= {shift_reg[6:0], 1'b1};
    end
  end

  // status code of a directly handled general call
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      code_reg <= 8'h00;
    end else if (state_reg == I2CCS_S_RX && scl_fall
                 && bit_reg == 4'h8 && direct_gc) begin
      code_reg <= shift_reg;
    end
  end

  // forced stop: pull data low, wait, release while clock is high
  always_ff @(posedge sys_clk) begin
    if (rst || !pe) begin
      fs_reg     <= I2CCS_F_IDLE;
      fs_cnt_reg <= 6'h0;
    end else begin
      unique case (fs_reg)
        I2CCS_F_IDLE: if (ctrl_reg[`I2CCS_FS_BIT]) begin
          fs_reg     <= I2CCS_F_LOW;
          fs_cnt_reg <= 6'h0;
        end
        I2CCS_F_LOW: begin
          fs_cnt_reg <= fs_cnt_reg + 6'h1;
          if (fs_cnt_reg >= half_cyc && scl_f) fs_reg <= I2CCS_F_REL;
        end
        I2CCS_F_REL: fs_reg <= I2CCS_F_IDLE;
      endcase
    end
  end

  // pin drivers: open drain, only the enables move
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sda_oe  <= 1'b0;
      scl_oe  <= 1'b0;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end else begin
      scl_oe <= pend_reg && !rx_in_ready; // stretch while queue full
      if (fs_reg == I2CCS_F_LOW) begin
        sda_oe <= 1'b1;
      end else if (!pe || state_reg == I2CCS_S_IDLE) begin
        sda_oe <= 1'b0;
      end else if (state_reg == I2CCS_S_TX && bit_reg < 4'h8) begin
        sda_oe <= ~shift_reg[7];
      end else if (state_reg != I2CCS_S_TX && bit_reg == 4'h8) begin
        sda_oe <= (state_reg == I2CCS_S_ADDR) ? match : !pend_reg;
      end else begin
        sda_oe <= 1'b0;
      end
    end
  end

  // flush timers: run a few cycles then clear the bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txf_cnt_reg <= 2'h0;
      rxf_cnt_reg <= 2'h0;
    end else begin
      txf_cnt_reg <= txf ? txf_cnt_reg + 2'h1 : 2'h0;
      rxf_cnt_reg <= rxf ? rxf_cnt_reg + 2'h1 : 2'h0;
    end
  end

  // bus_control write with byte lanes; a set beats a hardware clear
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready
                 && !s_axi_bvalid;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}}
                 & `I2CCS_CTRL_MASK;
  assign set_ones = (wr_go && s_axi_awaddr == `I2CCS_BUS_CONTROL_ADDR)
                    ? (s_axi_wdata & wmask) : 32'h0;
  always_comb begin
    hw_clr = 32'h0;
    hw_clr[`I2CCS_TXF_BIT] = (txf_cnt_reg == 2'(`I2CCS_FLUSH_CYC));
    hw_clr[`I2CCS_RXF_BIT] = (rxf_cnt_reg == 2'(`I2CCS_FLUSH_CYC));
    hw_clr[`I2CCS_DTX_BIT] = dma_tx_eot;
    hw_clr[`I2CCS_DRX_BIT] = dma_rx_eot;
    hw_clr[`I2CCS_FS_BIT]  = (fs_reg == I2CCS_F_REL);
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg <= `I2CCS_CTRL_RESET;
    end else if (wr_go && s_axi_awaddr == `I2CCS_BUS_CONTROL_ADDR) begin
      ctrl_reg <= ((ctrl_reg & ~wmask & ~hw_clr) | set_ones);
    end else begin
      ctrl_reg <= ctrl_reg & ~hw_clr;
    end
  end

  // dma requests follow enable and fifo room or data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dma_tx_req <= 1'b0;
      dma_rx_req <= 1'b0;
    end else begin
      dma_tx_req <= pe && ctrl_reg[`I2CCS_DTX_BIT] && !dma_tx_eot
                    && tx_in_ready && !txf;
      dma_rx_req <= pe && ctrl_reg[`I2CCS_DRX_BIT] && !dma_rx_eot
                    && rx_out_valid && !rxf;
    end
  end

  // write channel: both addr and data taken in one cycle
  assign wr_ok = (s_axi_awaddr == `I2CCS_BUS_CONTROL_ADDR) ||
                 (s_axi_awaddr == `I2CCS_TX_DATA_ADDR && tx_in_ready);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `I2CCS_RESP_OKAY;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `I2CCS_RESP_OKAY : `I2CCS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel; reading rx data pops the receive queue
  assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `I2CCS_RESP_OKAY;
    end else begin
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `I2CCS_RESP_OKAY;
        unique case (s_axi_araddr)
          `I2CCS_BUS_CONTROL_ADDR: s_axi_rdata <= ctrl_reg;
          `I2CCS_BUS_STATUS_ADDR: s_axi_rdata <= {20'h0,
            state_reg != I2CCS_S_IDLE, !tx_in_ready, rx_out_valid,
            fs_reg != I2CCS_F_IDLE, code_reg};
          `I2CCS_RX_DATA_ADDR: s_axi_rdata <= {23'h0, rx_out_valid,
                                              rx_out_data};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `I2CCS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // i2ccs_top
`default_nettype wire

//--- tb/i2ccs_top_monitor.sv
`default_nettype none
// handshake and request checks seen from the top ports only
module i2ccs_top_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sda_oe,
  input wire logic dma_tx_req,
  input wire logic dma_tx_eot,
  input wire logic dma_rx_req,
  input wire logic dma_rx_eot
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // write and read are answered one cycle after the offer
  property p_wr_ans;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
      |=> s_axi_awready && s_axi_wready && s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_rd_ans;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
      |=> s_axi_arready && s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  // readies pulse together for one cycle
  property p_rdy_pair;
    s_axi_awready |-> s_axi_wready ##1 !s_axi_awready;
  endproperty
  a_rdy_pair: assert property (p_rdy_pair) else $error("ready pulse bad");
  // a taken response does not linger
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("bvalid lingers");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done) else $error("rvalid lingers");
  // end of transfer drops the request within two edges
  property p_tx_eot;
    dma_tx_eot |-> ##[1:2] !dma_tx_req;
  endproperty
  a_tx_eot: assert property (p_tx_eot) else $error("tx req kept");
  property p_rx_eot;
    dma_rx_eot |-> ##[1:2] !dma_rx_req;
  endproperty
  a_rx_eot: assert property (p_rx_eot) else $error("rx req kept");
  // dma requests, both responses and the data drive quiet when reset lets go
  property p_rst_quiet;
    $fell(rst) |-> !dma_tx_req && !dma_rx_req && !s_axi_bvalid
      && !s_axi_rvalid && !sda_oe;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("busy at reset");
endmodule // i2ccs_top_monitor

bind i2ccs_top i2ccs_top_monitor i2ccs_top_monitor_inst (.*);
`default_nettype wire

//--- tb/i2ccs_bus_model.sv
`default_nettype none
// far-side bus master; lines are pulled low only, 800 ns bits
module i2ccs_bus_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // released lines idle high through the pull-ups
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic start();
    sda_low = 1'b1;
    #400 scl_low = 1'b1;
  endtask
  // data moves 200 ns after the fall so no false start or stop
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #200 sda_low = ~b[i];
      #200 scl_low = 1'b0;
      wait (scl === 1'b1);
      #400 scl_low = 1'b1;
    end
    #200 sda_low = 1'b0;
    #600 scl_low = 1'b0;
    #200 ack = ~sda;
    #200 scl_low = 1'b1;
    #600;
  endtask
  task automatic stop();
    #200 sda_low = 1'b1;
    #400 scl_low = 1'b0;
    #400 sda_low = 1'b0;
    #800;
  endtask
endmodule // i2ccs_bus_model
`default_nettype wire

//--- tb/test_i2c_control_settings.sv
`default_nettype none
module test_i2c_control_settings;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] base_ctl = 32'h0000_2011;
  logic        sys_clk = 1'b0, rst = 1'b1, dma_tx_eot = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, dma_rx_eot = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, scl_out, scl_oe, sda_out, sda_oe;
  logic        dma_tx_req, dma_rx_req, m_scl_low, m_sda_low;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire         scl_in, sda_in;
  int          bad_count = 0, comparisons = 0;
  // open-drain wires with pull-ups
  assign scl_in = ~(scl_oe | m_scl_low);
  assign sda_in = ~(sda_oe | m_sda_low);
  i2ccs_top i2ccs_top_inst (.*);
  i2ccs_bus_model i2ccs_bus_model_inst (
    .scl     (scl_in),
    .sda     (sda_in),
    .scl_low (m_scl_low),
    .sda_low (m_sda_low)
  );
  always #50 sys_clk = ~sys_clk;
  task automatic chk(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // both write channels offered together, held until answered
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    // no assumed latency: only the watchdog ends a lost answer
    do begin
      @(posedge sys_clk);
    end while (s_axi_bvalid !== 1'b1);
    chk("write resp", 32'(s_axi_bresp), 32'(er));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    s_axi_bready  <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b0;
    @(posedge sys_clk);
  endtask
  // self-clearing bits need a bounded reread, not a fixed wait
  task automatic poll(input logic [31:0] e, output logic [31:0] d);
    logic [1:0] r;
    for (int n = 0; n < 40; n++) begin
      rd(8'h00, d, r);
      if (d === e) break;
    end
  endtask
  task automatic frame(input logic [7:0] a, dt, output logic k1, k2);
    #20 i2ccs_bus_model_inst.start();
    i2ccs_bus_model_inst.send_byte(a, k1);
    i2ccs_bus_model_inst.send_byte(dt, k2);
    i2ccs_bus_model_inst.stop();
    @(posedge sys_clk);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rd(8'h00, d, r);
    chk("ctl reset", d, 32'h0);
    rd(8'h10, d, r);
    chk("unmapped", {d[29:0], r}, 32'h2);
    wr(8'h04, 32'hffff_ffff, 4'hf, 2'b10);
    wr(8'h00, 32'hffff_705d, 4'hf, 2'b00);
    rd(8'h00, d, r);
    chk("fields", d, 32'h0000_6055);
    wr(8'h00, 32'h0, 4'b0001, 2'b00);
    rd(8'h00, d, r);
    chk("lane 0", d, 32'h0000_6000);
  endtask
  task automatic t_link();
    logic [31:0] ctl [7] = '{base_ctl, base_ctl | 32'h4, base_ctl | 32'h2,
      base_ctl, base_ctl | 32'h40, base_ctl | 32'h40, 32'h0};
    logic [7:0]  ad [7] = '{8'haa, 8'haa, 8'haa, 8'h00, 8'h00, 8'h00, 8'haa};
    logic [7:0]  dt [7] = '{8'h3c, 8'h5a, 8'h11, 8'h06, 8'h04, 8'h01, 8'h3c};
    logic        ak [7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [8:0]  rx [7] = '{9'h13c, 9'h15a, 9'h0, 9'h106, 9'h0, 9'h101, 9'h0};
    logic [31:0] d;
    logic [1:0]  r;
    logic        k1, k2;
    for (int i = 0; i < 7; i++) begin
      wr(8'h00, ctl[i], 4'hf, 2'b00);
      frame(ad[i], dt[i], k1, k2);
      chk("ack", 32'({k1, k2}), 32'({ak[i], ak[i]}));
      chk("pins idle", 32'({scl_oe, scl_out, sda_out}), 32'h0);
      rd(8'h0c, d, r);
      chk("rx", d & (rx[i][8] ? 32'h1ff : 32'h100), 32'(rx[i]));
      if (ctl[i][6] && !dt[i][0]) begin
        rd(8'h04, d, r);
        chk("call code", 32'(d[7:0]), 32'(dt[i]));
      end
    end
  endtask
  // fill the tx queue until refused, then flush both sides
  task automatic t_flush();
    logic [31:0] d;
    logic [1:0]  r;
    logic        k1, k2;
    wr(8'h00, base_ctl, 4'hf, 2'b00);
    frame(8'haa, 8'h42, k1, k2);
    for (int i = 0; i < 5; i++) begin
      wr(8'h08, 32'(i), 4'hf, i < 4 ? 2'b00 : 2'b10);
    end
    rd(8'h04, d, r);
    chk("tx full", d & 32'h400, 32'h400);
    for (int b = 7; b <= 8; b++) begin
      wr(8'h00, base_ctl | (32'h1 << b), 4'hf, 2'b00);
      poll(base_ctl, d);
      chk("flush done", d, base_ctl);
    end
    rd(8'h04, d, r);
    chk("tx emptied", d & 32'h400, 32'h0);
    rd(8'h0c, d, r);
    chk("rx emptied", d & 32'h100, 32'h0);
  endtask
  task automatic dma_leg(input int b);
    logic [31:0] d;
    wr(8'h00, base_ctl | (32'h1 << b), 4'hf, 2'b00);
    repeat (3) @(posedge sys_clk);
    chk("req on", 32'({dma_rx_req, dma_tx_req}), 32'(b - 8));
    if (b == 9) begin
      dma_tx_eot <= 1'b1;
    end else begin
      dma_rx_eot <= 1'b1;
    end
    @(posedge sys_clk);
    dma_tx_eot <= 1'b0;
    dma_rx_eot <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("req off", 32'({dma_rx_req, dma_tx_req}), 32'h0);
    poll(base_ctl, d);
    chk("dma en cleared", d, base_ctl);
  endtask
  task automatic t_dma_stop();
    logic [31:0] d;
    logic [1:0]  r;
    logic        k1, k2, seen;
    dma_leg(9);
    frame(8'haa, 8'h77, k1, k2);
    chk("rx req idle", 32'(dma_rx_req), 32'h0);
    dma_leg(10);
    rd(8'h0c, d, r);
    wr(8'h00, base_ctl | 32'h8000, 4'hf, 2'b00);
    seen = 1'b0;
    for (int n = 0; n < 100 && !seen; n++) begin
      @(posedge sys_clk);
      seen = (sda_oe === 1'b1);
    end
    chk("stop drive", 32'(seen), 32'h1);
    poll(base_ctl, d);
    chk("stop done", d, base_ctl);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_link();
    t_flush();
    t_dma_stop();
    print_verdict();
  end
  // watchdog, far beyond the roughly 2000 cycles the run needs
  initial begin
    #2_000_000;
    bad_count++;
    print_verdict();
  end
endmodule // test_i2c_control_settings
`default_nettype wire
